//--- rtl/dtc_pkg.sv
// Package with register map, field positions and count constants of the timers.
package dtc_pkg;

  // Register offsets in the special function space.
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE_CFG = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h8E;

  // Bit addresses of the control register share this upper part.
  localparam logic [4:0] CTRL_BIT_BASE = 5'h11;

  // Control register bit positions.
  localparam int CT_EXT0_TYPE = 0;
  localparam int CT_EXT0_FLAG = 1;
  localparam int CT_EXT1_TYPE = 2;
  localparam int CT_EXT1_FLAG = 3;
  localparam int CT_RUN0 = 4;
  localparam int CT_OVF0 = 5;
  localparam int CT_RUN1 = 6;
  localparam int CT_OVF1 = 7;

  // Mode configuration: one nibble per timer, fields within the nibble.
  localparam int TM_T0_LSB = 0;
  localparam int TM_T1_LSB = 4;
  localparam int TM_MODE_LSB = 0;
  localparam int TM_CT = 2;
  localparam int TM_GATE = 3;

  // Clock control register bit positions of the rate selects.
  localparam int CK_RATE0 = 3;
  localparam int CK_RATE1 = 4;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_CFG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] RATE_RESET = 2'b00;
  localparam logic [7:0] UNIMPL_READ = 8'hFF;

  // Internal count rate: system clock divided by 4 or 12.
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;
  localparam logic [3:0] DIV_LAST = 4'(DIV_SLOW - 1);
  localparam logic [1:0] DIV_FAST_LAST = 2'(DIV_FAST - 1);

  // Pin indices of the synchronised input group.
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_EXT0 = 2;
  localparam int PIN_EXT1 = 3;
  localparam int PIN_COUNT = 4;

  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

endpackage

//--- rtl/dtc_pin_sync.sv
// Two-stage pin synchroniser with a falling-edge detector behind it.
`timescale 1ns/1ps
module dtc_pin_sync (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } dtc_sync_state_t;

  dtc_sync_state_t s_q;
  dtc_sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.sync;
  // sample pair edge: a high sample followed by a low one.
  assign fall_o = s_q.prev & ~s_q.sync;

endmodule // dtc_pin_sync

//--- rtl/dtc_top.sv
// Dual timer/counter with external interrupt flags behind the register port.
`timescale 1ns/1ps
module dtc_top
  import dtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic bit_wr_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wdata_i,
  input wire logic timer0_vector_i,
  input wire logic timer1_vector_i,
  input wire logic ext_irq0_vector_i,
  input wire logic ext_irq1_vector_i,
  input wire logic deep_sleep_request_i,
  input wire logic timer0_count_pin_i,
  input wire logic timer1_count_pin_i,
  input wire logic ext_irq_pin0_i,
  input wire logic ext_irq_pin1_i,
  output logic timer0_overflow_flag_o,
  output logic timer1_overflow_flag_o,
  output logic ext_irq0_flag_o,
  output logic ext_irq1_flag_o
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode_cfg;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [1:0] rate;
    logic [3:0] div;
    logic [7:0] rdata;
  } dtc_state_t;

  dtc_state_t s_q;
  dtc_state_t s_d;

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_fall;
  logic tick4;
  logic tick12;
  dtc_mode_t mode0;
  dtc_mode_t mode1;
  logic gate0;
  logic gate1;
  logic ct0;
  logic ct1;
  logic run0;
  logic run1;
  logic inc0;
  logic inc1;
  logic split_inc;
  logic ovf0;
  logic ovf1;
  logic ovf_split;
  logic ctrl_bit_hit;

  // Step one count in the modes that share a common layout.
  function automatic logic [16:0] dtc_step(input dtc_mode_t m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] p13;
    logic [16:0] w;
    logic [8:0] b;
    p13 = '0;
    w = '0;
    b = '0;
    case (m)
      // prescaled mode: the five prescaler bits carry into the high byte.
      // prescaler carry: high byte overflow raises the carry out.
      DTC_MODE_13: begin
        p13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        w = {p13[13], p13[12:5], lo[7:5], p13[4:0]};
      end
      // full count: both bytes as one 16-bit counter.
      DTC_MODE_16: begin
        w = {1'b0, hi, lo} + 17'h0_0001;
      end
      // auto reload: the low byte restarts from the high byte.
      DTC_MODE_RELOAD: begin
        b = {1'b0, lo} + 9'h001;
        w = {b[8], hi, (b[8] ? hi : b[7:0])};
      end
      default: begin
        w = {1'b0, hi, lo};
      end
    endcase
    return w;
  endfunction

  assign pin_raw[PIN_T0] = timer0_count_pin_i;
  assign pin_raw[PIN_T1] = timer1_count_pin_i;
  assign pin_raw[PIN_EXT0] = ext_irq_pin0_i;
  assign pin_raw[PIN_EXT1] = ext_irq_pin1_i;

  // Every pin passes two flip-flops before any counting logic sees it.
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      dtc_pin_sync u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pin_raw[i]),
        .level_o(pin_lvl[i]),
        .fall_o(pin_fall[i])
      );
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    // rate divider: ticks every 4th and every 12th clock.
    s_d.div = (s_q.div == DIV_LAST) ? 4'h0 : s_q.div + 4'h1;
    tick4 = (s_q.div[1:0] == DIV_FAST_LAST);
    tick12 = (s_q.div == DIV_LAST);
    mode0 = dtc_mode_t'(s_q.mode_cfg[TM_T0_LSB + TM_MODE_LSB +: 2]);
    mode1 = dtc_mode_t'(s_q.mode_cfg[TM_T1_LSB + TM_MODE_LSB +: 2]);
    gate0 = s_q.mode_cfg[TM_T0_LSB + TM_GATE];
    gate1 = s_q.mode_cfg[TM_T1_LSB + TM_GATE];
    ct0 = s_q.mode_cfg[TM_T0_LSB + TM_CT];
    ct1 = s_q.mode_cfg[TM_T1_LSB + TM_CT];
    // run control: the run bit enables counting.
    // gate control: gate adds the interrupt pin level as a condition.
    run0 = s_q.ctrl[CT_RUN0] & (~gate0 | pin_lvl[PIN_EXT0]);
    run1 = s_q.ctrl[CT_RUN1] & (~gate1 | pin_lvl[PIN_EXT1]);
    // count source: internal rate tick or count-pin falling edge.
    inc0 = run0 & (ct0 ? pin_fall[PIN_T0]
                       : (s_q.rate[0] ? tick4 : tick12));
    // timer 1 hold: mode 11 stops timer 1 outright.
    inc1 = run1 & (mode1 != DTC_MODE_SPLIT)
         & (ct1 ? pin_fall[PIN_T1] : (s_q.rate[1] ? tick4 : tick12));
    // split high byte: internal ticks under timer 1 run bit.
    split_inc = (mode0 == DTC_MODE_SPLIT) & s_q.ctrl[CT_RUN1]
              & (s_q.rate[0] ? tick4 : tick12);
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf_split = 1'b0;
    ctrl_bit_hit = bit_wr_i & (bit_addr_i[7:3] == CTRL_BIT_BASE);

    if (inc0) begin
      if (mode0 == DTC_MODE_SPLIT) begin
        // split low byte: plain 8-bit count on timer 0 controls.
        {ovf0, s_d.t0_low} = {1'b0, s_q.t0_low} + 9'h001;
      end else begin
        {ovf0, s_d.t0_high, s_d.t0_low} =
          dtc_step(mode0, s_q.t0_low, s_q.t0_high);
      end
    end
    if (split_inc) begin
      {ovf_split, s_d.t0_high} = {1'b0, s_q.t0_high} + 9'h001;
    end
    if (inc1) begin
      {ovf1, s_d.t1_high, s_d.t1_low} =
        dtc_step(mode1, s_q.t1_low, s_q.t1_high);
    end

    // direct access: byte writes by address, software beats counting.
    if (sfr_wr_i) begin
      if (sfr_addr_i == ADDR_CTRL) begin
        s_d.ctrl = sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_MODE_CFG) begin
        s_d.mode_cfg = sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_T0_LOW) begin
        s_d.t0_low = sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_T1_LOW) begin
        s_d.t1_low = sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_T0_HIGH) begin
        s_d.t0_high = sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_T1_HIGH) begin
        s_d.t1_high = sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_CLK_CTRL) begin
        s_d.rate = {sfr_wdata_i[CK_RATE1], sfr_wdata_i[CK_RATE0]};
      end
    end
    // single-bit access: only the control register takes bit writes.
    if (ctrl_bit_hit) begin
      s_d.ctrl[bit_addr_i[2:0]] = bit_wdata_i;
    end

    // vector clear: the overflow flags clear when serviced.
    if (timer0_vector_i) begin
      s_d.ctrl[CT_OVF0] = 1'b0;
    end
    if (timer1_vector_i) begin
      s_d.ctrl[CT_OVF1] = 1'b0;
    end
    // edge clear: vectoring clears only edge-triggered flags.
    if (ext_irq0_vector_i && s_q.ctrl[CT_EXT0_TYPE]) begin
      s_d.ctrl[CT_EXT0_FLAG] = 1'b0;
    end
    if (ext_irq1_vector_i && s_q.ctrl[CT_EXT1_TYPE]) begin
      s_d.ctrl[CT_EXT1_FLAG] = 1'b0;
    end

    // flag set: set is applied last so it wins over any clear.
    if (ovf0) begin
      s_d.ctrl[CT_OVF0] = 1'b1;
    end
    // split flag: the high byte borrows timer 1's overflow flag.
    if ((mode0 == DTC_MODE_SPLIT) ? ovf_split : ovf1) begin
      s_d.ctrl[CT_OVF1] = 1'b1;
    end
    // type coding: 1 selects falling edge, 0 selects low level.
    // edge or level: the type bit picks the detector per input.
    if (s_q.ctrl[CT_EXT0_TYPE]) begin
      if (pin_fall[PIN_EXT0]) begin
        s_d.ctrl[CT_EXT0_FLAG] = 1'b1;
      end
    end else begin
      // level follow: the flag tracks the pin in level mode.
      s_d.ctrl[CT_EXT0_FLAG] = ~pin_lvl[PIN_EXT0];
    end
    if (s_q.ctrl[CT_EXT1_TYPE]) begin
      if (pin_fall[PIN_EXT1]) begin
        s_d.ctrl[CT_EXT1_FLAG] = 1'b1;
      end
    end else begin
      s_d.ctrl[CT_EXT1_FLAG] = ~pin_lvl[PIN_EXT1];
    end

    // read ones: unimplemented bits and addresses read high.
    if (sfr_rd_i) begin
      if (sfr_addr_i == ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (sfr_addr_i == ADDR_MODE_CFG) begin
        s_d.rdata = s_q.mode_cfg;
      end else if (sfr_addr_i == ADDR_T0_LOW) begin
        s_d.rdata = s_q.t0_low;
      end else if (sfr_addr_i == ADDR_T1_LOW) begin
        s_d.rdata = s_q.t1_low;
      end else if (sfr_addr_i == ADDR_T0_HIGH) begin
        s_d.rdata = s_q.t0_high;
      end else if (sfr_addr_i == ADDR_T1_HIGH) begin
        s_d.rdata = s_q.t1_high;
      end else if (sfr_addr_i == ADDR_CLK_CTRL) begin
        s_d.rdata = UNIMPL_READ;
        s_d.rdata[CK_RATE1] = s_q.rate[1];
        s_d.rdata[CK_RATE0] = s_q.rate[0];
      end else begin
        s_d.rdata = UNIMPL_READ;
      end
    end

    // deep sleep: all state but the pin synchronisers freezes as if the clock had stopped.
    // Idle needs no input here because this block never stops in idle.
    if (deep_sleep_request_i) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.ctrl <= CTRL_RESET;
      s_q.mode_cfg <= MODE_CFG_RESET;
      s_q.t0_low <= COUNT_RESET;
      s_q.t0_high <= COUNT_RESET;
      s_q.t1_low <= COUNT_RESET;
      s_q.t1_high <= COUNT_RESET;
      s_q.rate <= RATE_RESET;
      s_q.div <= 4'h0;
      s_q.rdata <= UNIMPL_READ;
    end else begin
      s_q <= s_d;
    end
  end

  // control layout: flags and controls come straight from the register.
  assign timer0_overflow_flag_o = s_q.ctrl[CT_OVF0];
  assign timer1_overflow_flag_o = s_q.ctrl[CT_OVF1];
  assign ext_irq0_flag_o = s_q.ctrl[CT_EXT0_FLAG];
  assign ext_irq1_flag_o = s_q.ctrl[CT_EXT1_FLAG];
  assign sfr_rdata_o = s_q.rdata;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Wrap of the full 16-bit count, from all ones to zero with the flag.
  sequence full_wrap_s;
    inc0 && !deep_sleep_request_i && !sfr_wr_i && !bit_wr_i
      && mode0 == DTC_MODE_16 && s_q.t0_low == 8'hFF
      && s_q.t0_high == 8'hFF;
  endsequence
  sequence wrapped_s;
    s_q.t0_low == 8'h00 && s_q.t0_high == 8'h00 && s_q.ctrl[CT_OVF0];
  endsequence

  overflow_sets_a: assert property (
    ovf0 && !deep_sleep_request_i |=> s_q.ctrl[CT_OVF0])
    else $error("Timer 0 overflow did not set its flag.");

  stopped_holds_a: assert property (
    !s_q.ctrl[CT_RUN0] && !deep_sleep_request_i && !sfr_wr_i
      |=> s_q.t0_low == $past(s_q.t0_low))
    else $error("Timer 0 low byte moved while stopped.");

  level_tracks_a: assert property (
    !s_q.ctrl[CT_EXT0_TYPE] && !deep_sleep_request_i
      |=> s_q.ctrl[CT_EXT0_FLAG] == !$past(pin_lvl[PIN_EXT0]))
    else $error("Level interrupt flag does not follow the pin.");

  edge_sets_a: assert property (
    s_q.ctrl[CT_EXT0_TYPE] && pin_fall[PIN_EXT0] && !deep_sleep_request_i
      |=> s_q.ctrl[CT_EXT0_FLAG])
    else $error("Falling edge did not set the interrupt flag.");

  gate_blocks_a: assert property (
    gate0 && !pin_lvl[PIN_EXT0] |-> !inc0)
    else $error("Gated timer counted with its pin low.");

  count_source_a: assert property (
    inc0 && ct0 |-> $past(pin_lvl[PIN_T0]) && !pin_lvl[PIN_T0])
    else $error("Counter mode stepped without a pin fall.");

  full_wrap_a: assert property (
    full_wrap_s |=> wrapped_s)
    else $error("Sixteen-bit wrap went wrong.");

  reload_low_a: assert property (
    inc1 && mode1 == DTC_MODE_RELOAD && s_q.t1_low == 8'hFF
      && !deep_sleep_request_i && !sfr_wr_i
      |=> s_q.t1_low == $past(s_q.t1_high))
    else $error("Reload mode did not reload the low byte.");

  split_halt_a: assert property (
    mode1 == DTC_MODE_SPLIT |-> !inc1)
    else $error("Timer 1 counted in mode 11.");

  unmapped_ones_a: assert property (
    sfr_rd_i && !deep_sleep_request_i && sfr_addr_i < ADDR_CTRL
      |=> sfr_rdata_o == UNIMPL_READ)
    else $error("Unmapped read did not return ones.");

  slow_rate_a: assert property (
    inc0 && !ct0 && !s_q.rate[0] |-> s_q.div == DIV_LAST)
    else $error("Divide by 12 tick out of place.");

  sleep_freeze_a: assert property (
    deep_sleep_request_i |=> $stable(s_q.ctrl) && $stable(s_q.t0_low)
      && $stable(s_q.t1_low))
    else $error("State changed in deep sleep.");

endmodule // dtc_top

//--- tb/dtc_ext_pins.sv
// Model of the external count and interrupt pins facing the timers.
`timescale 1ns/1ps
module dtc_ext_pins (
  input wire logic clk_i,
  input wire logic [3:0] pulse_i,
  input wire logic [3:0] hold_low_i,
  input wire logic slow_i,
  output logic [3:0] pin_o
);
  int cnt [4];

  // A slow pulse stays low longer, so both sides of sync margin are used.
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (pulse_i[k]) begin
        cnt[k] <= slow_i ? 6 : 2;
      end else if (cnt[k] > 0) begin
        cnt[k] <= cnt[k] - 1;
      end
    end
  end

  // Pins idle high, as with a pull-up on the board.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pin_o[k] = !(hold_low_i[k] || cnt[k] > 0);
    end
  end
endmodule // dtc_ext_pins

//--- tb/test_dtc_top.sv
// Self-checking bench for the dual timer/counter block.
`timescale 1ns/1ps
module test_dtc_top;
  import dtc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] bit_addr = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bit_wr = 1'b0;
  logic bit_wdata = 1'b0;
  logic sleep = 1'b0;
  logic slow = 1'b0;
  logic [3:0] vec = 4'h0;
  logic [3:0] pulse = 4'h0;
  logic [3:0] hold = 4'h0;
  wire [3:0] pin;
  wire [3:0] flg;
  logic [31:0] seed = 32'h0000_0044;
  int mismatches = 0;
  int num_checks = 0;

  always #20 clk_i = ~clk_i;

  dtc_top u_dtc_top (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sfr_addr_i(addr),
    .sfr_wr_i(wr),
    .sfr_wdata_i(wdata),
    .sfr_rd_i(rd),
    .sfr_rdata_o(rdata),
    .bit_wr_i(bit_wr),
    .bit_addr_i(bit_addr),
    .bit_wdata_i(bit_wdata),
    .timer0_vector_i(vec[0]),
    .timer1_vector_i(vec[1]),
    .ext_irq0_vector_i(vec[2]),
    .ext_irq1_vector_i(vec[3]),
    .deep_sleep_request_i(sleep),
    .timer0_count_pin_i(pin[PIN_T0]),
    .timer1_count_pin_i(pin[PIN_T1]),
    .ext_irq_pin0_i(pin[PIN_EXT0]),
    .ext_irq_pin1_i(pin[PIN_EXT1]),
    .timer0_overflow_flag_o(flg[0]),
    .timer1_overflow_flag_o(flg[1]),
    .ext_irq0_flag_o(flg[2]),
    .ext_irq1_flag_o(flg[3])
  );

  dtc_ext_pins u_dtc_ext_pins (
    .clk_i(clk_i),
    .pulse_i(pulse),
    .hold_low_i(hold),
    .slow_i(slow),
    .pin_o(pin)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference count model; mode 3 stands for a plain 8-bit byte.
  function automatic bit step(int mode, int n, inout int lo, inout int hi);
    int v;
    bit o;
    o = 1'b0;
    case (mode)
      0: begin
        v = hi * 32 + lo % 32 + n;
        o = v > 8191;
        v = v % 8192;
        hi = v / 32;
        lo = lo / 32 * 32 + v % 32;
      end
      1: begin
        v = hi * 256 + lo + n;
        o = v > 65535;
        v = v % 65536;
        hi = v / 256;
        lo = v % 256;
      end
      2: begin
        for (int k = 0; k < n; k++) begin
          if (lo == 255) begin
            lo = hi;
            o = 1'b1;
          end else begin
            lo++;
          end
        end
      end
      default: begin
        o = lo + n > 255;
        lo = (lo + n) % 256;
      end
    endcase
    return o;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask

  // Sampled one cycle late; the read data holds until the next read.
  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask

  task automatic bitw(logic [7:0] a, logic v);
    @(negedge clk_i);
    bit_addr = a;
    bit_wdata = v;
    bit_wr = 1'b1;
    @(negedge clk_i);
    bit_wr = 1'b0;
  endtask

  task automatic vec_pulse(int i);
    @(negedge clk_i);
    vec[i] = 1'b1;
    @(negedge clk_i);
    vec[i] = 1'b0;
  endtask

  task automatic pin_pulse(int i);
    @(negedge clk_i);
    pulse[i] = 1'b1;
    @(negedge clk_i);
    pulse[i] = 1'b0;
    repeat (10) @(negedge clk_i);
  endtask

  task automatic wait_flag(int i, logic v);
    int n;
    n = 0;
    while (flg[i] !== v && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk({7'h00, flg[i]}, {7'h00, v}, "flag");
    if (flg[i] !== v) begin
      give_verdict();
    end
  endtask

  initial begin
    int lo, hi, lo_e, hi_e, n;
    logic [7:0] d, e, cfg;
    logic [31:0] r;
    bit o0, o1;
    repeat (5) @(negedge clk_i);
    arst_n_i = 1'b1;
    wr_reg(8'h8F, 8'h5A);
    for (int a = 8'h87; a < 8'h90; a++) begin
      rd_reg(8'(a), d);
      e = (a == 8'h8E) ? 8'hE7 : ((a < 8'h88 || a > 8'h8D) ? 8'hFF : 8'h00);
      chk(d, e, "reset value");
    end
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        r = rnd();
        lo = 240 + int'(r[3:0]);
        hi = (m == 2) ? int'(r[15:8]) : ((m == 3) ? 248 + int'(r[6:4]) : 255);
        cfg = t ? 8'(m << 4) : (8'h30 | 8'(m));
        wr_reg(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_MODE_CFG, cfg);
        wr_reg(ADDR_CLK_CTRL, {3'h0, r[16], r[16], 3'h0});
        wr_reg(t ? ADDR_T1_LOW : ADDR_T0_LOW, 8'(lo));
        wr_reg(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, 8'(hi));
        // Both run windows span 48 active edges, so the divider phase
        // does not change the number of steps.
        bitw(t ? 8'h8E : 8'h8C, 1'b1);
        bitw(t ? 8'h8C : 8'h8E, t == 0 && m == 3);
        repeat (5) @(negedge clk_i);
        if (m == 1) begin
          sleep = 1'b1;
          repeat (12) @(negedge clk_i);
          sleep = 1'b0;
        end
        repeat (39) @(negedge clk_i);
        bitw(t ? 8'h8E : 8'h8C, 1'b0);
        bitw(t ? 8'h8C : 8'h8E, 1'b0);
        n = r[16] ? 12 : 4;
        lo_e = lo;
        hi_e = hi;
        o0 = 1'b0;
        o1 = 1'b0;
        if (m == 3 && t == 0) begin
          o0 = step(3, n, lo_e, hi);
          o1 = step(3, n, hi_e, lo);
        end else if (m != 3) begin
          o0 = step(m, n, lo_e, hi_e);
        end
        e = t ? {o0, 7'h00} : {o1, 1'b0, o0, 5'h00};
        rd_reg(t ? ADDR_T1_LOW : ADDR_T0_LOW, d);
        chk(d, 8'(lo_e), "low byte");
        rd_reg(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, d);
        chk(d, 8'(hi_e), "high byte");
        rd_reg(ADDR_CTRL, d);
        chk(d, e, "control");
      end
    end
    for (int i = 0; i < 2; i++) begin
      bitw(i ? 8'h8F : 8'h8D, 1'b1);
      wait_flag(i, 1'b1);
      vec_pulse(i);
      wait_flag(i, 1'b0);
    end
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_MODE_CFG, 8'h3D);
    wr_reg(ADDR_T0_LOW, 8'h00);
    wr_reg(ADDR_T0_HIGH, 8'h00);
    bitw(8'h8C, 1'b1);
    r = rnd();
    slow = r[0];
    repeat (3) pin_pulse(PIN_T0);
    hold[PIN_EXT0] = 1'b1;
    wait_flag(2, 1'b1);
    repeat (2) pin_pulse(PIN_T0);
    vec_pulse(2);
    repeat (3) @(negedge clk_i);
    chk({7'h00, flg[2]}, 8'h01, "level flag");
    hold[PIN_EXT0] = 1'b0;
    wait_flag(2, 1'b0);
    bitw(8'h8C, 1'b0);
    rd_reg(ADDR_T0_LOW, d);
    chk(d, 8'h03, "pin count");
    bitw(8'h8A, 1'b1);
    pin_pulse(PIN_EXT1);
    chk({7'h00, flg[3]}, 8'h01, "edge flag");
    vec_pulse(3);
    wait_flag(3, 1'b0);
    // Timer 1 as a gated pin counter; the last pulse falls while gated.
    wr_reg(ADDR_MODE_CFG, 8'hD0);
    wr_reg(ADDR_T1_LOW, 8'h00);
    bitw(8'h8E, 1'b1);
    repeat (2) pin_pulse(PIN_T1);
    hold[PIN_EXT1] = 1'b1;
    pin_pulse(PIN_T1);
    bitw(8'h8E, 1'b0);
    hold[PIN_EXT1] = 1'b0;
    rd_reg(ADDR_T1_LOW, d);
    chk(d, 8'h02, "timer 1 pin count");
    chk({7'h00, flg[3]}, 8'h01, "gate pin edge");
    give_verdict();
  end
endmodule // test_dtc_top
